/* File: logic/pcp_top.sv */
// Device side of the byte-wide parallel configuration port with upgrade page select
`timescale 1ns/1ps
module pcp_top (
   // Clock and reset
   input  wire logic                  clock_i,
   input  wire logic                  rst_i,
   // Device configuration state
   input  wire pcp_pkg::pcp_scheme_t  scheme_i,
   input  wire logic                  config_start_i,
   input  wire logic                  config_done_i,
   input  wire logic                  user_mode_i,
   input  wire logic                  upgrade_enable_i,
   input  wire logic [2:0]            page_value_i,
   // Host pins
   input  wire logic                  chip_select_low_i,
   input  wire logic                  chip_select_high_i,
   input  wire logic                  write_strobe_n_i,
   input  wire logic                  read_strobe_n_i,
   input  wire logic [7:0]            config_bus_i,
   input  wire logic                  update_source_select_i,
   // Driven pins, enables low while driving
   output logic                       config_bus_msb_o,
   output logic                       config_bus_msb_oe_n_o,
   output logic                       ready_busy_flag_o,
   output logic                       ready_busy_flag_oe_n_o,
   output logic [2:0]                 page_select_out_o,
   output logic                       page_select_oe_n_o,
   // Captured bytes towards the frame loader
   output logic [7:0]                 byte_data_o,
   output logic                       byte_valid_o,
   input  wire logic                  byte_ready_i,
   // Status towards the device core
   output logic                       remote_update_o,
   output logic                       upgrade_pins_active_o,
   output logic                       user_io_release_o,
   output logic                       selected_o
);
   import pcp_pkg::*;

   pcp_phase_t       phase;
   pcp_phase_t       next_phase;
   logic [4:0]       pin_ctrl_raw;
   logic [4:0]       pin_ctrl;
   logic [7:0]       bus_level;
   logic             ws_n_prev;
   logic             busy;
   logic             is_ppa;
   logic             sel;
   logic             ws_rise;
   logic             take_byte;
   logic             consume;
   logic             port_owned;
   logic             upgrade_active;
   logic             next_ready;

   assign pin_ctrl_raw[POS_WS_N]    = write_strobe_n_i;
   assign pin_ctrl_raw[POS_RS_N]    = read_strobe_n_i;
   assign pin_ctrl_raw[POS_CS_LOW]  = chip_select_low_i;
   assign pin_ctrl_raw[POS_CS_HIGH] = chip_select_high_i;
   assign pin_ctrl_raw[POS_UPD_SEL] = update_source_select_i;

   pcp_sync #(
      .WIDTH   (PIN_CTRL_W),
      .RST_VAL (PIN_CTRL_RST)
   ) u_sync_ctrl (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .pin_i   (pin_ctrl_raw),
      .level_o (pin_ctrl)
   );

   // Data takes the same path length as the write strobe, so the edge sees settled data
   pcp_sync #(
      .WIDTH   (BYTE_W),
      .RST_VAL (BYTE_RST)
   ) u_sync_bus (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .pin_i   (config_bus_i),
      .level_o (bus_level)
   );

   assign is_ppa = (scheme_i == parallel_async_scheme);
   // Both selects must agree; a host using one ties the other active
   assign sel = ~pin_ctrl[POS_CS_LOW] & pin_ctrl[POS_CS_HIGH];
   // Port is owned from power-up until user mode, only in the parallel async scheme
   assign port_owned = is_ppa && (phase != PH_USER);
   assign ws_rise = ~ws_n_prev & pin_ctrl[POS_WS_N];
   // A write while busy breaks the host handshake and is dropped rather than overwriting
   assign take_byte = ws_rise && sel && is_ppa && (phase == PH_CONFIG) && !busy;
   assign consume = byte_valid_o && byte_ready_i;

   // Phase sequence of the surrounding configuration controller
   always_comb begin
      next_phase = phase;
      case (phase)
         PH_POWER_UP: begin
            if (config_start_i) begin
               next_phase = PH_CONFIG;
            end
         end
         PH_CONFIG: begin
            if (config_done_i) begin
               next_phase = PH_INIT;
            end
         end
         PH_INIT: begin
            if (user_mode_i) begin
               next_phase = PH_USER;
            end
         end
         PH_USER: begin
            next_phase = PH_USER;
         end
         default: begin
            next_phase = PH_POWER_UP;
         end
      endcase
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         phase <= PH_POWER_UP;
      end else begin
         phase <= next_phase;
      end
   end

   // Strobe edge detector on the filtered level only
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         ws_n_prev <= 1'b1;
      end else begin
         ws_n_prev <= pin_ctrl[POS_WS_N];
      end
   end

   // Byte holding register and busy state; one byte in flight at a time
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         byte_data_o  <= BYTE_RST;
         byte_valid_o <= 1'b0;
         busy         <= 1'b0;
      end else begin
         if (take_byte) begin
            byte_data_o  <= bus_level;
            byte_valid_o <= 1'b1;
            busy         <= 1'b1;
         end else if (consume) begin
            byte_valid_o <= 1'b0;
            busy         <= 1'b0;
         end
      end
   end

   // Busy only counts in configuration; before and after it the flag shows ready
   assign next_ready = (phase == PH_CONFIG) ? !(busy || take_byte) : 1'b1;

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         ready_busy_flag_o      <= 1'b1;
         ready_busy_flag_oe_n_o <= 1'b1;
         config_bus_msb_o       <= 1'b1;
         config_bus_msb_oe_n_o  <= 1'b1;
      end else begin
         ready_busy_flag_o      <= next_ready;
         ready_busy_flag_oe_n_o <= !port_owned;
         config_bus_msb_o       <= next_ready;
         // An unused read strobe held high never turns the MSB driver on
         config_bus_msb_oe_n_o  <= !(port_owned && sel && !pin_ctrl[POS_RS_N]);
      end
   end

   // Upgrade pins: remote or local select in passive and parallel async schemes only
   assign upgrade_active = upgrade_enable_i && (scheme_i != serial_active_scheme);

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         remote_update_o    <= 1'b0;
         page_select_out_o  <= PAGE_RST;
         page_select_oe_n_o <= 1'b1;
      end else begin
         remote_update_o    <= upgrade_active && pin_ctrl[POS_UPD_SEL];
         page_select_out_o  <= upgrade_active ? page_value_i : PAGE_RST;
         page_select_oe_n_o <= !upgrade_active;
      end
   end

   // Status; a host dropping select mid-configuration simply stalls the stream
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         upgrade_pins_active_o <= 1'b0;
         user_io_release_o     <= 1'b0;
         selected_o            <= 1'b0;
      end else begin
         upgrade_pins_active_o <= upgrade_active;
         user_io_release_o     <= !port_owned;
         selected_o            <= sel && is_ppa;
      end
   end

endmodule // pcp_top

/* File: logic/pcp_pkg.sv */
// Constants, enumerations and reset values for the parallel configuration port handshake
package pcp_pkg;

   // Configuration schemes selected by the mode straps
   typedef enum logic [1:0] {
      parallel_async_scheme,
      fast_parallel_passive_scheme,
      serial_passive_scheme,
      serial_active_scheme
   } pcp_scheme_t;

   // Device configuration phases seen by the port
   typedef enum logic [1:0] {
      PH_POWER_UP,
      PH_CONFIG,
      PH_INIT,
      PH_USER
   } pcp_phase_t;

   localparam int         BYTE_W       = 8;
   localparam int         PAGE_W       = 3;
   localparam int         PIN_CTRL_W   = 5;
   localparam int         MSB_POS      = 7;
   localparam int         SYNC_STAGES  = 3;
   localparam logic [7:0] BYTE_RST     = 8'h00;
   localparam logic [2:0] PAGE_RST     = 3'h0;

   // Positions of the control pins in the synchroniser bundle
   localparam int         POS_WS_N     = 0;
   localparam int         POS_RS_N     = 1;
   localparam int         POS_CS_LOW   = 2;
   localparam int         POS_CS_HIGH  = 3;
   localparam int         POS_UPD_SEL  = 4;
   // Idle pin levels loaded at reset: strobes high, device deselected
   localparam logic [4:0] PIN_CTRL_RST = 5'h07;

endpackage

/* File: logic/pcp_sync.sv */
// Three-stage pin synchroniser whose output follows once stages two and three agree
`timescale 1ns/1ps
module pcp_sync #(
   parameter int         WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // Clock and reset
   input  wire logic             clock_i,
   input  wire logic             rst_i,
   // Pins and filtered levels
   input  wire logic [WIDTH-1:0] pin_i,
   output logic      [WIDTH-1:0] level_o
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   // Stage one is read by stage two only, to keep metastability out of the filter
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         stage1 <= RST_VAL;
         stage2 <= RST_VAL;
         stage3 <= RST_VAL;
      end else begin
         stage1 <= pin_i;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // Per-bit agreement filter rejects single-cycle glitches
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         level_o <= RST_VAL;
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            if (stage2[i] == stage3[i]) begin
               level_o[i] <= stage3[i];
            end
         end
      end
   end

endmodule // pcp_sync

/* File: test/pcp_top_assertions.sv */
// Concurrent checks on the ports of the parallel configuration port
`timescale 1ns/1ps
module pcp_top_assertions (
   // Clock, reset and state
   input wire logic                 clock_i,
   input wire logic                 rst_i,
   input wire pcp_pkg::pcp_scheme_t scheme_i,
   input wire logic                 upgrade_enable_i,
   input wire logic [2:0]           page_value_i,
   // Host pins and loader ready
   input wire logic                 chip_select_high_i,
   input wire logic                 read_strobe_n_i,
   input wire logic                 update_source_select_i,
   input wire logic                 byte_ready_i,
   // Outputs
   input wire logic                 config_bus_msb_o,
   input wire logic                 config_bus_msb_oe_n_o,
   input wire logic                 ready_busy_flag_o,
   input wire logic                 ready_busy_flag_oe_n_o,
   input wire logic [2:0]           page_select_out_o,
   input wire logic                 page_select_oe_n_o,
   input wire logic [7:0]           byte_data_o,
   input wire logic                 byte_valid_o,
   input wire logic                 remote_update_o
);
   import pcp_pkg::*;
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   pins_released_a: assert property (scheme_i != parallel_async_scheme |=>
      ready_busy_flag_oe_n_o && config_bus_msb_oe_n_o) else $error("pins driven off scheme");
   msb_flag_a: assert property (!config_bus_msb_oe_n_o |->
      config_bus_msb_o == ready_busy_flag_o) else $error("msb differs from flag");
   read_idle_a: assert property (read_strobe_n_i [*6] |-> config_bus_msb_oe_n_o)
      else $error("msb driven without read");
   deselect_a: assert property (!chip_select_high_i [*6] |-> config_bus_msb_oe_n_o)
      else $error("msb driven while deselected");
   busy_hold_a: assert property (byte_valid_o |-> !ready_busy_flag_o)
      else $error("ready while byte pending");
   valid_hold_a: assert property (byte_valid_o && !byte_ready_i |=>
      byte_valid_o && $stable(byte_data_o)) else $error("pending byte lost");
   accept_ready_a: assert property (byte_valid_o && byte_ready_i |=>
      !byte_valid_o ##1 ready_busy_flag_o) else $error("no ready after accept");
   page_off_a: assert property (!upgrade_enable_i || scheme_i == serial_active_scheme |=>
      page_select_oe_n_o && page_select_out_o == 3'h0) else $error("page pins driven");
   page_on_a: assert property (!rst_i && upgrade_enable_i
      && scheme_i != serial_active_scheme |=> !page_select_oe_n_o
      && page_select_out_o == $past(page_value_i)) else $error("page wrong");
   remote_sel_a: assert property ((!rst_i && upgrade_enable_i
      && scheme_i != serial_active_scheme && $stable(update_source_select_i)) [*6]
      |-> remote_update_o == update_source_select_i) else $error("update source wrong");
endmodule // pcp_top_assertions
bind pcp_top pcp_top_assertions pcp_top_assertions_i (.*);

/* File: test/pcp_host_model.sv */
// Host controller that drives the selects, strobes and byte bus
`timescale 1ns/1ps
module pcp_host_model (
   // Clock and ready pin
   input  wire logic clock_i,
   input  wire logic ready_i,
   // Host pins
   output logic      chip_select_low_o,
   output logic      chip_select_high_o,
   output logic      write_strobe_n_o,
   output logic      read_strobe_n_o,
   output logic [7:0] bus_o
);
   initial begin
      chip_select_low_o = 1'h0;
      chip_select_high_o = 1'h1;
      write_strobe_n_o = 1'h1;
      read_strobe_n_o = 1'h1;
      bus_o = 8'hFF;
   end
   task automatic write_byte(input logic [7:0] b, input logic wait_rdy, input int low);
      for (int n = 0; n < 200 && wait_rdy && !ready_i; n++)
         @(posedge clock_i);
      @(posedge clock_i);
      // Wrong data at the falling strobe, so a capture there cannot look right
      bus_o <= ~b;
      write_strobe_n_o <= 1'h0;
      @(posedge clock_i);
      bus_o <= b;
      repeat (low - 1) @(posedge clock_i);
      write_strobe_n_o <= 1'h1;
      // Busy shows five edges after the rising strobe; leaving sooner would miss it
      repeat (6) @(posedge clock_i);
      // Released bus shows the inverse so a late capture cannot look right
      bus_o <= ~b;
   endtask
   task automatic set_ctl(input logic rd, input logic sel);
      @(posedge clock_i);
      read_strobe_n_o <= ~rd;
      chip_select_high_o <= sel;
   endtask
endmodule // pcp_host_model

/* File: test/pcp_top_tb.sv */
// Self-checking bench for the parallel configuration port handshake
`timescale 1ns/1ps
module pcp_top_tb;
   import pcp_pkg::*;
   logic clock_i, rst_i, config_start_i, config_done_i, user_mode_i, upgrade_enable_i;
   logic chip_select_low_i, chip_select_high_i, write_strobe_n_i, read_strobe_n_i;
   logic update_source_select_i, byte_ready_i, stall, msb_w, rdy_w, byte_valid_o;
   logic config_bus_msb_o, config_bus_msb_oe_n_o, ready_busy_flag_o, ready_busy_flag_oe_n_o;
   logic page_select_oe_n_o, remote_update_o, upgrade_pins_active_o, user_io_release_o;
   logic selected_o;
   logic [2:0] page_value_i, page_select_out_o;
   logic [7:0] config_bus_i, host_bus, byte_data_o, b;
   pcp_scheme_t scheme_i;
   logic [7:0] exp_q[$];
   int fail_count, checked;
   // An undriven ready pin shows the inverse of its last value
   assign rdy_w = ready_busy_flag_o ^ ready_busy_flag_oe_n_o;
   assign msb_w = config_bus_msb_oe_n_o ? host_bus[7] : config_bus_msb_o;
   assign config_bus_i = {msb_w, host_bus[6:0]};
   pcp_top pcp_top_i (.*);
   pcp_host_model pcp_host_model_i (.clock_i(clock_i), .ready_i(rdy_w),
      .chip_select_low_o(chip_select_low_i), .chip_select_high_o(chip_select_high_i),
      .write_strobe_n_o(write_strobe_n_i), .read_strobe_n_o(read_strobe_n_i), .bus_o(host_bus));
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      checked++;
      if (seen !== want) begin
         fail_count++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock_i);
   endtask
   task automatic do_reset(input pcp_scheme_t s);
      rst_i <= 1'h1;
      scheme_i <= s;
      cyc(2);
      rst_i <= 1'h0;
      cyc(4);
   endtask
   initial begin
      clock_i = 1'h0;
      forever #50 clock_i = ~clock_i;
   end
   initial begin
      #2_000_000;
      fail_count++;
      wrap_up();
   end
   always @(posedge clock_i) begin
      byte_ready_i <= stall ? 1'h0 : 1'($urandom % 2);
      if (byte_valid_o && byte_ready_i)
         check(byte_data_o, exp_q.size() ? exp_q.pop_front() : 8'hXX);
   end
   initial begin
      {rst_i, stall, config_start_i, config_done_i, user_mode_i} = 5'h18;
      {upgrade_enable_i, update_source_select_i, page_value_i} = 5'h00;
      scheme_i = parallel_async_scheme;
      void'($urandom(32'h51c475bb));
      do_reset(parallel_async_scheme);
      check(ready_busy_flag_o, 8'h01);
      check(ready_busy_flag_oe_n_o, 8'h00);
      pcp_host_model_i.set_ctl(1'h1, 1'h1);
      cyc(6);
      check(msb_w, 8'h01);
      check(config_bus_msb_oe_n_o, 8'h00);
      pcp_host_model_i.set_ctl(1'h0, 1'h1);
      config_start_i <= 1'h1;
      cyc(1);
      config_start_i <= 1'h0;
      stall <= 1'h0;
      cyc(6);
      repeat (12) begin
         b = 8'($urandom);
         exp_q.push_back(b);
         pcp_host_model_i.write_byte(b, 1'h1, 3 + $urandom % 4);
      end
      for (int i = 0; i < 50 && exp_q.size() > 0; i++) cyc(1);
      stall <= 1'h1;
      exp_q.push_back(~b);
      pcp_host_model_i.write_byte(~b, 1'h1, 3);
      pcp_host_model_i.write_byte(b, 1'h0, 3);
      pcp_host_model_i.set_ctl(1'h1, 1'h1);
      cyc(6);
      check(msb_w, 8'h00);
      stall <= 1'h0;
      cyc(10);
      check(msb_w, 8'h01);
      check(8'(exp_q.size()), 8'h00);
      pcp_host_model_i.set_ctl(1'h1, 1'h0);
      cyc(6);
      check(selected_o, 8'h00);
      check(config_bus_msb_oe_n_o, 8'h01);
      pcp_host_model_i.write_byte(8'h5A, 1'h0, 3);
      pcp_host_model_i.set_ctl(1'h0, 1'h1);
      cyc(6);
      check(selected_o, 8'h01);
      upgrade_enable_i <= 1'h1;
      for (int p = 0; p < 8; p++) begin
         page_value_i <= 3'(p);
         update_source_select_i <= p[0];
         cyc(8);
         check(page_select_out_o, 8'(p));
         check(remote_update_o, p[0]);
         check(upgrade_pins_active_o, 8'h01);
      end
      config_done_i <= 1'h1;
      cyc(1);
      config_done_i <= 1'h0;
      user_mode_i <= 1'h1;
      cyc(1);
      user_mode_i <= 1'h0;
      cyc(3);
      check(ready_busy_flag_oe_n_o, 8'h01);
      check(user_io_release_o, 8'h01);
      for (int s = 1; s < 4; s++) begin
         do_reset(pcp_scheme_t'(s));
         check(ready_busy_flag_oe_n_o, 8'h01);
         check(page_select_oe_n_o, 8'(s == 3));
         check(upgrade_pins_active_o, 8'(s != 3));
      end
      wrap_up();
   end
endmodule // pcp_top_tb
